// >>> hdl/ssr_cfg.svh
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH

// register byte offsets
`define SSR_OFF_CFG      8'h00
`define SSR_OFF_SP1      8'h04
`define SSR_OFF_SP2      8'h08
`define SSR_OFF_SLOPE    8'h0C
`define SSR_OFF_HOLD     8'h10
`define SSR_OFF_STATUS   8'h14
`define SSR_OFF_INT_STAT 8'h18
`define SSR_OFF_INT_CLR  8'h1C
`define SSR_OFF_INT_EN   8'h20
`define SSR_OFF_RAMP     8'h24

// field positions inside the config register
`define SSR_CFG_EIF_LSB  0
`define SSR_CFG_FMT_BIT  4
`define SSR_CFG_SPM_LSB  8
`define SSR_CFG_PVM_LSB  12
`define SSR_CFG_A1_BIT   16
`define SSR_CFG_A2_BIT   17

// reset values
`define SSR_CFG_RST      32'h0000_0000
`define SSR_HOLD_RST     16'h0000

// timing: one second in clock cycles at 250 MHz
`define SSR_CLK_HZ       250000000
`define SSR_SEC_S        1
`define SSR_SEC_CYCLES   (`SSR_CLK_HZ * `SSR_SEC_S)
// slope divisors in seconds
`define SSR_DIV_MIN      24'h00003C
`define SSR_DIV_HOUR     24'h000E10

// error codes
`define SSR_ERR_NONE     4'h0
`define SSR_ERR_IN1      4'h1
`define SSR_ERR_IN2      4'h2
`define SSR_ERR_DWELL    4'h4

`endif

// >>> hdl/ssr_pkg.sv
`default_nettype none
package ssr_pkg;
    typedef logic signed [15:0] ssr_val_t;

    typedef enum logic [3:0] {
        EV_NONE = 4'h0, EV_ALT_SP = 4'h1, EV_ALT_TUNE = 4'h2,
        EV_BOTH = 4'h3, EV_CLR_A1 = 4'h4, EV_CLR_A2 = 4'h5,
        EV_CLR_A12 = 4'h6, EV_DIS_O1 = 4'h7, EV_DIS_O2 = 4'h8,
        EV_DIS_O12 = 4'h9, EV_LOCK = 4'hA
    } ssr_evfn_e;

    typedef enum logic [2:0] {
        SPM_DUAL = 3'h0, SPM_PER_MIN = 3'h1, SPM_PER_HOUR = 3'h2,
        SPM_REM_IN1 = 3'h3, SPM_REM_IN2 = 3'h4
    } ssr_spm_e;

    typedef enum logic [1:0] {
        PVM_IN1 = 2'h0, PVM_IN2 = 2'h1, PVM_DIFF12 = 2'h2, PVM_DIFF21 = 2'h3
    } ssr_pvm_e;

    typedef enum logic [1:0] {
        RS_IDLE = 2'b01, RS_RUN = 2'b10
    } ssr_ramp_e;

    typedef enum logic [2:0] {
        DW_WAIT = 3'b001, DW_COUNT = 3'b010, DW_DONE = 3'b100
    } ssr_dwell_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ssr_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ssr_apb_rsp_s;

    typedef struct packed {
        ssr_apb_rsp_s      apb;
        logic [31:0]       cfg;
        ssr_val_t          sp1;
        ssr_val_t          sp2;
        logic [15:0]       slope;
        logic [15:0]       hold;
        logic [3:0]        int_stat;
        logic [3:0]        int_en;
        logic [31:0]       sec_cnt;
        logic              sec_tick;
        logic              init;
        ssr_ramp_e         ramp_st;
        ssr_val_t          ramp_val;
        logic [23:0]       ramp_acc;
        ssr_val_t          last_target;
        logic              key_seen;
        ssr_dwell_e [1:0]  dwell_st;
        logic [1:0][15:0]  dwell_cnt;
        logic [1:0]        alarm;
        ssr_val_t          ctl_sp;
        ssr_val_t          disp;
        logic              alt_tune;
        logic              tw1;
        logic              tw2;
        logic [3:0]        err;
        logic              irq;
    } ssr_state_s;
endpackage
`default_nettype wire

// >>> hdl/ssr_setpoint_ctl.sv
// Notes on behaviour
// - absolute format: alternate set point is the stored secondary value
// - offset format: alternate set point is primary plus secondary
// - alternate set point function with event active controls to it
// - alternate set point honoured only in dual or ramp source modes
// - combined function switches set point and tuning set together
// - finished auto-tune stores into the set the event selected
// - ramping only in per-minute or per-hour mode, rate from slope
// - ramp starts at power up and on every set point change
// - ramp value loads process value on power up, slope or set point change
// - zero slope disables ramping, target applied directly
// - display shows ramp value while ramping, set point once a key touched
// - dwell function makes an alarm act as dwell timer
// - dwell counts from process reaching set point, alarms at expiry
// - hold change before expiry does not disturb the running count
// - dwell alarm stays until reset or alarm-clear event input
// - dwell on both alarms gives a configuration error code
// - remote input one or two swaps set point and process routing
// - both sources on input one or both on input two give errors
// - alarm-clear event clears alarm; on release it retriggers if present
`include "ssr_cfg.svh"
`default_nettype none
module ssr_setpoint_ctl #(
    parameter int unsigned SEC_CYCLES = `SSR_SEC_CYCLES
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire ssr_pkg::ssr_apb_req_s apb_req,
    output var  ssr_pkg::ssr_apb_rsp_s apb_rsp,
    input  wire logic                  event_in,
    input  wire ssr_pkg::ssr_val_t     input_one_value,
    input  wire ssr_pkg::ssr_val_t     input_two_value,
    input  wire logic                  key_touch,
    input  wire logic                  autotune_done,
    input  wire logic                  alarm_one_condition,
    input  wire logic                  alarm_two_condition,
    output logic                       irq,
    output ssr_pkg::ssr_val_t          control_setpoint,
    output ssr_pkg::ssr_val_t          display_value,
    output logic                       alt_tuning_select,
    output logic                       tune_write_first,
    output logic                       tune_write_second,
    output logic                       alarm_one_out,
    output logic                       alarm_two_out,
    output logic [3:0]                 error_code
);
    ssr_pkg::ssr_state_s q_reg;
    ssr_pkg::ssr_state_s q_next;

    // unmapped offsets answer with pslverr
    function automatic logic addr_ok(input logic [7:0] a);
        unique case (a)
            `SSR_OFF_CFG, `SSR_OFF_SP1, `SSR_OFF_SP2, `SSR_OFF_SLOPE,
            `SSR_OFF_HOLD, `SSR_OFF_STATUS, `SSR_OFF_INT_STAT,
            `SSR_OFF_INT_CLR, `SSR_OFF_INT_EN, `SSR_OFF_RAMP:
                addr_ok = 1'b1;
            default:
                addr_ok = 1'b0;
        endcase
    endfunction

    always_comb begin
        ssr_pkg::ssr_evfn_e evf;
        ssr_pkg::ssr_spm_e  spm;
        ssr_pkg::ssr_pvm_e  pvm;
        ssr_pkg::ssr_val_t  pv;
        ssr_pkg::ssr_val_t  alt_sp;
        ssr_pkg::ssr_val_t  target;
        logic [1:0]         dwell_on;
        logic [1:0]         clr_al;
        logic [1:0]         cond;
        logic [3:0]         ev_set;
        logic [3:0]         clr_mask;
        logic               ramp_mode;
        logic               ramp_en;
        logic               alt_on;
        logic               restart;
        logic               wr;
        logic [23:0]        div;
        logic [7:0]         a;
        q_next   = q_reg;
        pv       = '0;
        alt_sp   = '0;
        target   = '0;
        clr_al   = '0;
        div      = '0;
        ramp_en  = 1'b0;
        alt_on   = 1'b0;
        restart  = 1'b0;
        ramp_mode = 1'b0;
        evf      = ssr_pkg::ssr_evfn_e'(q_reg.cfg[`SSR_CFG_EIF_LSB +: 4]);
        spm      = ssr_pkg::ssr_spm_e'(q_reg.cfg[`SSR_CFG_SPM_LSB +: 3]);
        pvm      = ssr_pkg::ssr_pvm_e'(q_reg.cfg[`SSR_CFG_PVM_LSB +: 2]);
        dwell_on = {q_reg.cfg[`SSR_CFG_A2_BIT], q_reg.cfg[`SSR_CFG_A1_BIT]};
        cond     = {alarm_two_condition, alarm_one_condition};
        ev_set   = 4'h0;
        clr_mask = 4'h0;
        a        = apb_req.paddr;
        wr       = apb_req.psel && apb_req.penable && q_reg.apb.pready &&
                   apb_req.pwrite && addr_ok(a);

        // second tick divider, a one-cycle enable
        q_next.sec_tick = 1'b0;
        q_next.sec_cnt  = q_reg.sec_cnt + 32'h1;
        if (q_reg.sec_cnt >= 32'(SEC_CYCLES - 1)) begin
            q_next.sec_cnt  = 32'h0;
            q_next.sec_tick = 1'b1;
        end

        unique case (pvm)
            ssr_pkg::PVM_IN1:    pv = input_one_value;
            ssr_pkg::PVM_IN2:    pv = input_two_value;
            ssr_pkg::PVM_DIFF12: pv = input_one_value - input_two_value;
            ssr_pkg::PVM_DIFF21: pv = input_two_value - input_one_value;
        endcase
        if (spm == ssr_pkg::SPM_REM_IN1) pv = input_two_value;
        if (spm == ssr_pkg::SPM_REM_IN2) pv = input_one_value;

        alt_sp = q_reg.cfg[`SSR_CFG_FMT_BIT] ? q_reg.sp1 + q_reg.sp2
                                              : q_reg.sp2;
        ramp_mode = (spm == ssr_pkg::SPM_PER_MIN) ||
                    (spm == ssr_pkg::SPM_PER_HOUR);
        alt_on = event_in && (ramp_mode || spm == ssr_pkg::SPM_DUAL) &&
                 (evf == ssr_pkg::EV_ALT_SP || evf == ssr_pkg::EV_BOTH);
        target = alt_on ? alt_sp : q_reg.sp1;
        if (spm == ssr_pkg::SPM_REM_IN1) target = input_one_value;
        if (spm == ssr_pkg::SPM_REM_IN2) target = input_two_value;

        // tuning set follows the same event
        q_next.alt_tune = event_in && (evf == ssr_pkg::EV_ALT_TUNE ||
                                       evf == ssr_pkg::EV_BOTH);
        // store results in the selected set
        q_next.tw1 = autotune_done && !q_reg.alt_tune;
        q_next.tw2 = autotune_done && q_reg.alt_tune;

        // ramp mode and rate; zero slope disables
        ramp_en = ramp_mode && (q_reg.slope != 16'h0000);
        div = (spm == ssr_pkg::SPM_PER_HOUR) ? `SSR_DIV_HOUR
                                              : `SSR_DIV_MIN;
        // any config or slope write, or a change of target, re-arms the ramp
        restart = q_reg.init || (target != q_reg.last_target) ||
                  (wr && (a == `SSR_OFF_SLOPE || a == `SSR_OFF_CFG));
        q_next.init        = 1'b0;
        q_next.last_target = target;
        if (restart) begin
            q_next.ramp_val = pv;
            q_next.ramp_acc = 24'h0;
            q_next.key_seen = 1'b0;
            q_next.ramp_st  = ramp_en ? ssr_pkg::RS_RUN : ssr_pkg::RS_IDLE;
        end else begin
            unique case (q_reg.ramp_st)
                ssr_pkg::RS_IDLE: begin
                    q_next.ramp_acc = 24'h0;
                end
                ssr_pkg::RS_RUN: begin
                    if (!ramp_en) begin
                        q_next.ramp_st = ssr_pkg::RS_IDLE;
                    end else if (q_reg.ramp_val == target) begin
                        q_next.ramp_st = ssr_pkg::RS_IDLE;
                        ev_set[2]      = 1'b1;
                    end else if (q_reg.sec_tick) begin
                        q_next.ramp_acc = q_reg.ramp_acc +
                                          {8'h00, q_reg.slope};
                    end else if (q_reg.ramp_acc >= div) begin
                        // drain one divisor per cycle between ticks, stepping the ramp value by one
                        q_next.ramp_acc = q_reg.ramp_acc - div;
                        q_next.ramp_val = (q_reg.ramp_val < target) ?
                            q_reg.ramp_val + 16'sh0001 :
                            q_reg.ramp_val - 16'sh0001;
                    end
                end
            endcase
        end
        if (key_touch) q_next.key_seen = 1'b1;
        q_next.ctl_sp = (q_reg.ramp_st == ssr_pkg::RS_RUN) ?
                        q_reg.ramp_val : target;
        // ramp value shown until a key is touched
        q_next.disp = (q_reg.ramp_st == ssr_pkg::RS_RUN &&
                       !q_reg.key_seen) ? q_reg.ramp_val : target;

        clr_al[0] = event_in && (evf == ssr_pkg::EV_CLR_A1 ||
                                 evf == ssr_pkg::EV_CLR_A12);
        clr_al[1] = event_in && (evf == ssr_pkg::EV_CLR_A2 ||
                                 evf == ssr_pkg::EV_CLR_A12);
        for (int k = 0; k < 2; k++) begin
            if (!dwell_on[k]) begin
                q_next.dwell_st[k]  = ssr_pkg::DW_WAIT;
                q_next.dwell_cnt[k] = 16'h0;
                // latched alarm cleared while event held
                q_next.alarm[k] = !clr_al[k] && (q_reg.alarm[k] || cond[k]);
            end else begin
                unique case (q_reg.dwell_st[k])
                    ssr_pkg::DW_WAIT: begin
                        // count starts when set point reached
                        if (pv >= target && !clr_al[k]) begin
                            q_next.dwell_st[k]  = ssr_pkg::DW_COUNT;
                            q_next.dwell_cnt[k] = 16'h0;
                        end
                    end
                    ssr_pkg::DW_COUNT: begin
                        if (q_reg.dwell_cnt[k] >= q_reg.hold) begin
                            q_next.dwell_st[k] = ssr_pkg::DW_DONE;
                        end else if (q_reg.sec_tick) begin
                            q_next.dwell_cnt[k] = q_reg.dwell_cnt[k] + 16'h1;
                        end
                    end
                    ssr_pkg::DW_DONE: begin
                        if (clr_al[k]) begin
                            q_next.dwell_st[k]  = ssr_pkg::DW_WAIT;
                            q_next.dwell_cnt[k] = 16'h0;
                        end
                    end
                    default: begin
                        q_next.dwell_st[k] = ssr_pkg::DW_WAIT;
                    end
                endcase
                q_next.alarm[k] = (q_next.dwell_st[k] == ssr_pkg::DW_DONE);
            end
            if (q_next.alarm[k] && !q_reg.alarm[k]) ev_set[k] = 1'b1;
        end

        // dwell on both alarms, same-input conflicts
        if (dwell_on == 2'b11) begin
            q_next.err = `SSR_ERR_DWELL;
        end else if (spm == ssr_pkg::SPM_REM_IN1 &&
                     pvm == ssr_pkg::PVM_IN1) begin
            q_next.err = `SSR_ERR_IN1;
        end else if (spm == ssr_pkg::SPM_REM_IN2 &&
                     pvm == ssr_pkg::PVM_IN2) begin
            q_next.err = `SSR_ERR_IN2;
        end else begin
            q_next.err = `SSR_ERR_NONE;
        end
        if (q_next.err != `SSR_ERR_NONE && q_reg.err == `SSR_ERR_NONE)
            ev_set[3] = 1'b1;

        // apb: pready one cycle after access starts; write at the edge where pready is sampled high
        q_next.apb.pready  = 1'b0;
        q_next.apb.pslverr = 1'b0;
        if (apb_req.psel && apb_req.penable && !q_reg.apb.pready) begin
            q_next.apb.pready  = 1'b1;
            q_next.apb.pslverr = !addr_ok(a);
            unique case (a)
                `SSR_OFF_CFG:      q_next.apb.prdata = q_reg.cfg;
                `SSR_OFF_SP1:      q_next.apb.prdata = 32'(q_reg.sp1);
                `SSR_OFF_SP2:      q_next.apb.prdata = 32'(q_reg.sp2);
                `SSR_OFF_SLOPE:    q_next.apb.prdata = {16'h0, q_reg.slope};
                `SSR_OFF_HOLD:     q_next.apb.prdata = {16'h0, q_reg.hold};
                `SSR_OFF_STATUS:   q_next.apb.prdata = {23'h0,
                    q_reg.alt_tune, alt_on, q_reg.alarm,
                    q_reg.ramp_st == ssr_pkg::RS_RUN, q_reg.err};
                `SSR_OFF_INT_STAT: q_next.apb.prdata = {28'h0, q_reg.int_stat};
                `SSR_OFF_INT_EN:   q_next.apb.prdata = {28'h0, q_reg.int_en};
                `SSR_OFF_RAMP:     q_next.apb.prdata = {16'h0, q_reg.ramp_val};
                default:           q_next.apb.prdata = 32'h0;
            endcase
        end
        if (wr) begin
            unique case (a)
                `SSR_OFF_CFG:     q_next.cfg    = apb_req.pwdata;
                `SSR_OFF_SP1:     q_next.sp1    = apb_req.pwdata[15:0];
                `SSR_OFF_SP2:     q_next.sp2    = apb_req.pwdata[15:0];
                `SSR_OFF_SLOPE:   q_next.slope  = apb_req.pwdata[15:0];
                `SSR_OFF_HOLD:    q_next.hold   = apb_req.pwdata[15:0];
                `SSR_OFF_INT_CLR: clr_mask      = apb_req.pwdata[3:0];
                `SSR_OFF_INT_EN:  q_next.int_en = apb_req.pwdata[3:0];
                default:          clr_mask      = 4'h0;
            endcase
        end
        // sticky status: a new event wins over a clear
        q_next.int_stat = (q_reg.int_stat & ~clr_mask) | ev_set;
        q_next.irq      = |(q_next.int_stat & q_next.int_en);
    end

    // single state register
    always_ff @(posedge clk) begin
        if (rst) begin
            q_reg          <= '0;
            q_reg.cfg      <= `SSR_CFG_RST;
            q_reg.hold     <= `SSR_HOLD_RST;
            q_reg.init     <= 1'b1;  // power-up ramp load
            q_reg.ramp_st  <= ssr_pkg::RS_IDLE;
            q_reg.dwell_st <= '{ssr_pkg::DW_WAIT, ssr_pkg::DW_WAIT};
        end else begin
            q_reg <= q_next;
        end
    end

    assign apb_rsp           = q_reg.apb;
    assign irq               = q_reg.irq;
    assign control_setpoint  = q_reg.ctl_sp;
    assign display_value     = q_reg.disp;
    assign alt_tuning_select = q_reg.alt_tune;
    assign tune_write_first  = q_reg.tw1;
    assign tune_write_second = q_reg.tw2;
    assign alarm_one_out     = q_reg.alarm[0];
    assign alarm_two_out     = q_reg.alarm[1];
    assign error_code        = q_reg.err;
endmodule
`default_nettype wire

// >>> testbench/ssr_event_src.sv
`default_nettype none
// event contact source: a switch or plc that closes after a delay
module ssr_event_src #(
    parameter int DELAY = 3
) (
    input  wire logic clk,
    input  wire logic close_req,
    output logic      event_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DELAY:0] dly_reg = '0;

    // slow contact: the request shows on the wire only DELAY+1 edges later
    always_ff @(posedge clk) begin
        dly_reg <= {dly_reg[DELAY-1:0], close_req};
    end
    assign event_in = dly_reg[DELAY];
endmodule
`default_nettype wire

// >>> testbench/ssr_setpoint_ctl_properties.sv
`default_nettype none
module ssr_props (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire ssr_pkg::ssr_apb_req_s apb_req,
    input wire ssr_pkg::ssr_apb_rsp_s apb_rsp,
    input wire logic                  event_in,
    input wire logic                  autotune_done,
    input wire logic                  alt_tuning_select,
    input wire logic                  tune_write_first,
    input wire logic                  tune_write_second,
    input wire logic                  alarm_one_out,
    input wire logic                  alarm_two_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // first access cycle, then a single-cycle answer
    sequence acc_wait;
        apb_req.psel && apb_req.penable && !apb_rsp.pready;
    endsequence
    sequence rdy_pulse;
        apb_rsp.pready ##1 !apb_rsp.pready;
    endsequence

    apb_answer_a: assert property (acc_wait |=> rdy_pulse)
        else $error("pready did not follow the access phase");
    apb_origin_a: assert property (apb_rsp.pready |-> $past(apb_req.penable))
        else $error("pready without an access phase");
    tune_pair_a: assert property (autotune_done |=>
        tune_write_first != tune_write_second)
        else $error("tuning store not exactly one bank");
    tune_bank_a: assert property (autotune_done |=>
        tune_write_second == $past(alt_tuning_select))
        else $error("tuning stored into the wrong bank");
    tune_cause_a: assert property (
        tune_write_first || tune_write_second |-> $past(autotune_done))
        else $error("tuning store without completion");
    alt_tune_cause_a: assert property (
        $rose(alt_tuning_select) |-> $past(event_in))
        else $error("second tuning set without event");
    // latched alarms only drop on a clear event (or reset)
    alarm_one_hold_a: assert property ($fell(alarm_one_out) |->
        $past(event_in) || $past(rst))
        else $error("alarm one dropped without clear event");
    alarm_two_hold_a: assert property ($fell(alarm_two_out) |->
        $past(event_in) || $past(rst))
        else $error("alarm two dropped without clear event");
endmodule

bind ssr_setpoint_ctl ssr_props props_u (
    .clk               (clk),
    .rst               (rst),
    .apb_req           (apb_req),
    .apb_rsp           (apb_rsp),
    .event_in          (event_in),
    .autotune_done     (autotune_done),
    .alt_tuning_select (alt_tuning_select),
    .tune_write_first  (tune_write_first),
    .tune_write_second (tune_write_second),
    .alarm_one_out     (alarm_one_out),
    .alarm_two_out     (alarm_two_out)
);
`default_nettype wire

// >>> testbench/ssr_setpoint_ctl_bench.sv
`include "ssr_cfg.svh"
`default_nettype none
module ssr_setpoint_ctl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // short second keeps ramp and dwell runs small
    localparam int SEC = 20;
    localparam logic [2:0] RSPM [4] = '{3'h3, 3'h4, 3'h3, 3'h4};
    localparam logic [1:0] RPVM [4] = '{2'h0, 2'h1, 2'h1, 2'h0};
    localparam logic [3:0] RERR [4] = '{4'h1, 4'h2, 4'h0, 4'h0};
    localparam logic AFMT [6] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1};
    localparam logic AEV [6] = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1};
    localparam logic [2:0] ASPM [6] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3};
    localparam logic [31:0] ACSP [6] = '{32'h64, 32'hC8, 32'h12C,
        32'h12C, 32'h12C, 32'h123};
    logic                  clk = 1'h0;
    logic                  rst = 1'h1;
    ssr_pkg::ssr_apb_req_s req = '0;
    ssr_pkg::ssr_apb_rsp_s rsp;
    logic                  ev_req = 1'h0;
    logic                  event_in;
    ssr_pkg::ssr_val_t     in1 = '0;
    logic                  key = 1'h0;
    logic                  tune = 1'h0;
    logic                  cond = 1'h0;
    logic                  irq, alt_tune, tw1, tw2, al1, al2;
    ssr_pkg::ssr_val_t     csp, disp;
    logic [3:0]            err_code;
    logic [31:0]           q;
    logic                  e;
    int                    errors = 0;
    int                    comparisons = 0;

    always #2 clk = ~clk;

    ssr_setpoint_ctl #(.SEC_CYCLES(SEC)) dut_u (
        .clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
        .event_in(event_in), .input_one_value(in1),
        .input_two_value(16'sh0456), .key_touch(key),
        .autotune_done(tune), .alarm_one_condition(cond),
        .alarm_two_condition(cond), .irq(irq), .control_setpoint(csp),
        .display_value(disp), .alt_tuning_select(alt_tune),
        .tune_write_first(tw1), .tune_write_second(tw2),
        .alarm_one_out(al1), .alarm_two_out(al2), .error_code(err_code));
    ssr_event_src ev_u (.clk(clk), .close_req(ev_req), .event_in(event_in));

    task automatic summarize();
        $display("counts: %0d comparisons, %0d errors", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    // one apb transfer; holds the request until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        @(posedge clk);
        req <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'h1 && n < 50);
        if (n >= 50) begin
            errors++;
            summarize();
        end
        q = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'h1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        xfer(1'h0, a, 32'h0);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    function automatic logic [31:0] mk(input logic [3:0] ev, input logic f,
        input logic [2:0] spm, input logic [1:0] pvm, input logic [1:0] dw);
        mk = 32'(ev) << `SSR_CFG_EIF_LSB | 32'(f) << `SSR_CFG_FMT_BIT
           | 32'(spm) << `SSR_CFG_SPM_LSB | 32'(pvm) << `SSR_CFG_PVM_LSB
           | 32'(dw) << `SSR_CFG_A1_BIT;
    endfunction

    initial begin
        cyc(4);
        rst <= 1'h0;
        // reset values and an unmapped offset
        rd(`SSR_OFF_CFG);
        chk("cfg reset", q, `SSR_CFG_RST);
        rd(`SSR_OFF_HOLD);
        chk("hold reset", q, 32'(`SSR_HOLD_RST));
        rd(`SSR_OFF_INT_CLR);
        chk("clear reads zero", q, 32'h0);
        rd(8'h40);
        chk("unmapped slverr", e, 32'h1);
        $display("test reset done");
        // remote routing and source conflicts
        in1 <= 16'sh0123;
        for (int i = 0; i < 4; i++) begin
            wr(`SSR_OFF_CFG, mk(4'h0, 1'h0, RSPM[i], RPVM[i], 2'h0));
            cyc(3);
            chk("error code", err_code, RERR[i]);
            rd(`SSR_OFF_RAMP);
            if (i > 1) chk("rem sp", csp, i == 2 ? 32'h123 : 32'h456);
            if (i > 1) chk("rem pv", q, i == 2 ? 32'h456 : 32'h123);
        end
        $display("test remote done");
        // alternate set point across formats and source modes
        wr(`SSR_OFF_SLOPE, 32'h0);
        wr(`SSR_OFF_SP1, 32'h64);
        wr(`SSR_OFF_SP2, 32'hC8);
        for (int i = 0; i < 6; i++) begin
            wr(`SSR_OFF_CFG, mk(4'h1, AFMT[i], ASPM[i], 2'h0, 2'h0));
            ev_req <= AEV[i];
            cyc(8);
            chk("alt sp", csp, ACSP[i]);
        end
        $display("test alternate done");
        // combined function and tuning bank on completion
        wr(`SSR_OFF_CFG, mk(4'h3, 1'h0, 3'h0, 2'h0, 2'h0));
        for (int i = 0; i < 2; i++) begin
            ev_req <= 1'(i == 0);
            cyc(8);
            chk("alt tune", alt_tune, i == 0);
            chk("combined sp", csp, i == 0 ? 32'hC8 : 32'h64);
            tune <= 1'h1;
            @(posedge clk);
            tune <= 1'h0;
            @(posedge clk);
            chk("tune bank", {tw2, tw1}, i == 0 ? 32'h2 : 32'h1);
        end
        $display("test tuning done");
        // ramp in per-minute then per-hour mode, same rate
        for (int i = 0; i < 2; i++) begin
            in1 <= 16'sh0000;
            wr(`SSR_OFF_CFG, mk(4'h0, 1'h0, 3'(i + 1), 2'h0, 2'h0));
            wr(`SSR_OFF_SLOPE, i == 0 ? 32'h3C : 32'hE10);
            wr(`SSR_OFF_SP1, 32'hA);
            cyc(3);
            chk("ramp start", 32'(csp < 16'sh3), 32'h1);
            chk("ramp shown", 32'(disp < 16'sh3), 32'h1);
            key <= 1'h1;
            @(posedge clk);
            key <= 1'h0;
            cyc(3);
            chk("key shows sp", disp, 32'hA);
            cyc(5 * SEC);
            chk("ramp rate", 32'(csp > 16'sh2 && csp < 16'sh8), 32'h1);
            cyc(8 * SEC);
            chk("ramp end", csp, 32'hA);
        end
        $display("test ramp done");
        // dwell: hold change mid-count must not restart the count
        wr(`SSR_OFF_CFG, mk(4'h4, 1'h0, 3'h0, 2'h0, 2'h1));
        wr(`SSR_OFF_HOLD, 32'h3);
        in1 <= 16'sh000A;
        cyc(30);
        wr(`SSR_OFF_HOLD, 32'h6);
        cyc(30);
        chk("dwell counting", al1, 32'h0);
        cyc(66);
        chk("dwell expired", al1, 32'h1);
        in1 <= 16'sh0000;
        cyc(40);
        chk("dwell holds", al1, 32'h1);
        ev_req <= 1'h1;
        cyc(8);
        chk("dwell cleared", al1, 32'h0);
        ev_req <= 1'h0;
        cyc(8);
        chk("dwell stays off", al1, 32'h0);
        wr(`SSR_OFF_CFG, mk(4'h4, 1'h0, 3'h0, 2'h0, 2'h3));
        cyc(3);
        chk("dwell conflict", err_code, 32'h4);
        $display("test dwell done");
        // alarm clear with retrigger, then interrupt mask and clear
        wr(`SSR_OFF_CFG, mk(4'h6, 1'h0, 3'h0, 2'h0, 2'h0));
        wr(`SSR_OFF_INT_EN, 32'h0);
        wr(`SSR_OFF_INT_CLR, 32'hF);
        cond <= 1'h1;
        cyc(4);
        chk("alarms latch", {al2, al1}, 32'h3);
        ev_req <= 1'h1;
        cyc(8);
        chk("alarms cleared", {al2, al1}, 32'h0);
        ev_req <= 1'h0;
        cyc(8);
        chk("alarms retrigger", {al2, al1}, 32'h3);
        rd(`SSR_OFF_INT_STAT);
        chk("stat alarm one", q[0], 32'h1);
        chk("irq masked", irq, 32'h0);
        wr(`SSR_OFF_INT_EN, 32'h1);
        cyc(2);
        chk("irq raised", irq, 32'h1);
        wr(`SSR_OFF_INT_CLR, 32'h1);
        cyc(2);
        chk("irq dropped", irq, 32'h0);
        rd(`SSR_OFF_INT_STAT);
        chk("stat cleared", q[0], 32'h0);
        $display("test alarm done");
        summarize();
    end
endmodule
`default_nettype wire
